/* logic/analog_out_pkg.sv */
`default_nettype none
package analog_out_pkg;
	// =========================================
	// register offsets
	localparam logic [7:0] OUT0_DATA_LOW_ADDR = 8'hf9;
	localparam logic [7:0] OUT0_DATA_HIGH_ADDR = 8'hfa;
	localparam logic [7:0] OUT1_DATA_LOW_ADDR = 8'hfb;
	localparam logic [7:0] OUT1_DATA_HIGH_ADDR = 8'hfc;
	localparam logic [7:0] ANALOG_OUT_CONTROL_ADDR = 8'hfd;
	// =========================================
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h04;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// =========================================
	// control field positions
	localparam int MODE_8BIT_BIT = 7;
	localparam int CH1_SPAN_BIT = 6;
	localparam int CH0_SPAN_BIT = 5;
	localparam int CH1_FORCE_ZERO_N_BIT = 4;
	localparam int CH0_FORCE_ZERO_N_BIT = 3;
	localparam int ASYNC_UPDATE_BIT = 2;
	localparam int CH1_POWER_ON_BIT = 1;
	localparam int CH0_POWER_ON_BIT = 0;
endpackage : analog_out_pkg
`default_nettype wire

/* logic/out_channel.sv */
`timescale 1ns/10ps
`default_nettype none
// one output channel: code latch, clear, span and power
module out_channel (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic load,
	input wire logic [11:0] code_in,
	input wire logic force_zero_n,
	input wire logic span_sel,
	input wire logic power_on,
	// analog stage
	output logic [11:0] code_out,
	output logic span_supply,
	output logic drive_en
);
	logic [11:0] code_q;

	// =========================================
	// code latch
	// latched code survives a clear so releasing it restores the level
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			code_q <= 12'h000;
		end else if (load) begin
			code_q <= code_in;
		end
	end

	// =========================================
	// output stage drive
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			code_out <= 12'h000;
			span_supply <= 1'b0;
			drive_en <= 1'b0;
		end else begin
			code_out <= force_zero_n ? (load ? code_in : code_q) : 12'h000;
			span_supply <= span_sel;
			drive_en <= power_on;
		end
	end
endmodule : out_channel
`default_nettype wire

/* logic/analog_out_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// special function register side of the dual output converter
module analog_out_ctrl (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// internal register bus
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// channel 0 analog stage
	output logic [11:0] ch0_code,
	output logic ch0_span_supply,
	output logic ch0_drive_en,
	// channel 1 analog stage
	output logic [11:0] ch1_code,
	output logic ch1_span_supply,
	output logic ch1_drive_en,
	// pin sharing with analog inputs 4 and 5
	output logic analog_input_4_avail,
	output logic analog_input_5_avail
);
	logic [7:0] control_q;
	logic [7:0] out0_low_q;
	logic [7:0] out0_high_q;
	logic [7:0] out1_low_q;
	logic [7:0] out1_high_q;
	logic wr_ctrl;
	logic wr_l0;
	logic wr_h0;
	logic wr_l1;
	logic wr_h1;
	logic mode_8bit;
	logic async_now;
	logic sync_release;
	logic load0;
	logic load1;
	logic [11:0] code0_next;
	logic [11:0] code1_next;
	logic [7:0] l0_eff;
	logic [7:0] l1_eff;
	logic [7:0] h0_eff;
	logic [7:0] h1_eff;
	logic ch0_en;
	logic ch1_en;

	// assemble a code from its data bytes: low byte alone in 8-bit mode, else high byte low nibble and low byte
	function automatic logic [11:0] join_code(input logic eight_bit, input logic [7:0] lo,
			input logic [7:0] hi);
		if (eight_bit) begin
			join_code = {lo, 4'h0};
		end else begin
			join_code = {hi[3:0], lo};
		end
	endfunction : join_code

	// =========================================
	// address decode
	assign wr_ctrl = sfr_wr && (sfr_addr == analog_out_pkg::ANALOG_OUT_CONTROL_ADDR);
	assign wr_l0 = sfr_wr && (sfr_addr == analog_out_pkg::OUT0_DATA_LOW_ADDR);
	assign wr_h0 = sfr_wr && (sfr_addr == analog_out_pkg::OUT0_DATA_HIGH_ADDR);
	assign wr_l1 = sfr_wr && (sfr_addr == analog_out_pkg::OUT1_DATA_LOW_ADDR);
	assign wr_h1 = sfr_wr && (sfr_addr == analog_out_pkg::OUT1_DATA_HIGH_ADDR);

	// =========================================
	// control register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			control_q <= analog_out_pkg::CONTROL_RESET;
		end else if (wr_ctrl) begin
			control_q <= sfr_wdata;
		end
	end

	// =========================================
	// data registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out0_low_q <= analog_out_pkg::DATA_RESET;
			out0_high_q <= analog_out_pkg::DATA_RESET;
			out1_low_q <= analog_out_pkg::DATA_RESET;
			out1_high_q <= analog_out_pkg::DATA_RESET;
		end else begin
			if (wr_l0) begin
				out0_low_q <= sfr_wdata;
			end
			if (wr_h0) begin
				out0_high_q <= sfr_wdata;
			end
			if (wr_l1) begin
				out1_low_q <= sfr_wdata;
			end
			if (wr_h1) begin
				out1_high_q <= sfr_wdata;
			end
		end
	end

	// =========================================
	// load decisions
	// the byte being written this cycle is used directly so the load needs no
	// extra cycle behind the register write
	assign mode_8bit = control_q[analog_out_pkg::MODE_8BIT_BIT];
	assign async_now = control_q[analog_out_pkg::ASYNC_UPDATE_BIT];
	assign sync_release = wr_ctrl && !async_now
		&& sfr_wdata[analog_out_pkg::ASYNC_UPDATE_BIT];
	assign l0_eff = wr_l0 ? sfr_wdata : out0_low_q;
	assign l1_eff = wr_l1 ? sfr_wdata : out1_low_q;
	assign h0_eff = wr_h0 ? sfr_wdata : out0_high_q;
	assign h1_eff = wr_h1 ? sfr_wdata : out1_high_q;
	// high byte writes never load: only a low byte write in async mode or a sync release commits a code
	assign load0 = (async_now && wr_l0) || sync_release;
	assign load1 = (async_now && wr_l1) || sync_release;
	// release takes the mode being written with it
	assign code0_next = join_code(sync_release ? sfr_wdata[analog_out_pkg::MODE_8BIT_BIT]
		: mode_8bit, l0_eff, h0_eff);
	assign code1_next = join_code(sync_release ? sfr_wdata[analog_out_pkg::MODE_8BIT_BIT]
		: mode_8bit, l1_eff, h1_eff);

	// =========================================
	// channels
	out_channel u_ch0 (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(load0),
		.code_in(code0_next),
		.force_zero_n(control_q[analog_out_pkg::CH0_FORCE_ZERO_N_BIT]),
		.span_sel(control_q[analog_out_pkg::CH0_SPAN_BIT]),
		.power_on(control_q[analog_out_pkg::CH0_POWER_ON_BIT]),
		.code_out(ch0_code),
		.span_supply(ch0_span_supply),
		.drive_en(ch0_en)
	);

	out_channel u_ch1 (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(load1),
		.code_in(code1_next),
		.force_zero_n(control_q[analog_out_pkg::CH1_FORCE_ZERO_N_BIT]),
		.span_sel(control_q[analog_out_pkg::CH1_SPAN_BIT]),
		.power_on(control_q[analog_out_pkg::CH1_POWER_ON_BIT]),
		.code_out(ch1_code),
		.span_supply(ch1_span_supply),
		.drive_en(ch1_en)
	);

	// =========================================
	// pin sharing
	// input side of a shared pin is lost while the channel drives it
	assign ch0_drive_en = ch0_en;
	assign ch1_drive_en = ch1_en;
	assign analog_input_4_avail = !ch0_en;
	assign analog_input_5_avail = !ch1_en;

	// =========================================
	// read back
	// unmapped addresses read zero and drop sfr_hit so other blocks can answer
	always_comb begin
		sfr_hit = 1'b1;
		unique case (sfr_addr)
			analog_out_pkg::OUT0_DATA_LOW_ADDR: sfr_rdata = out0_low_q;
			analog_out_pkg::OUT0_DATA_HIGH_ADDR: sfr_rdata = out0_high_q;
			analog_out_pkg::OUT1_DATA_LOW_ADDR: sfr_rdata = out1_low_q;
			analog_out_pkg::OUT1_DATA_HIGH_ADDR: sfr_rdata = out1_high_q;
			analog_out_pkg::ANALOG_OUT_CONTROL_ADDR: sfr_rdata = control_q;
			default: begin
				sfr_rdata = 8'h00;
				sfr_hit = 1'b0;
			end
		endcase
	end
endmodule : analog_out_ctrl
`default_nettype wire

/* test/analog_out_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// =====
// output checker
module analog_out_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register bus
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	// channels
	input wire logic [11:0] ch0_code,
	input wire logic [11:0] ch1_code,
	input wire logic ch0_span_supply,
	input wire logic ch1_span_supply,
	input wire logic ch0_drive_en,
	input wire logic ch1_drive_en,
	input wire logic analog_input_4_avail,
	input wire logic analog_input_5_avail
);
	logic [7:0] ctl_q;
	wire cw = sfr_wr && sfr_addr == analog_out_pkg::ANALOG_OUT_CONTROL_ADDR;
	// control shadow, so the checks need no view inside
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) ctl_q <= analog_out_pkg::CONTROL_RESET;
		else if (cw) ctl_q <= sfr_wdata;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// =====
	// properties
	property p_span;
		cw ##1 !cw |=> {ch1_span_supply, ch0_span_supply} == $past(sfr_wdata[6:5], 2);
	endproperty
	a_span: assert property (p_span) else $error("span mismatch");
	property p_pwr;
		cw ##1 !cw |=> {ch1_drive_en, ch0_drive_en} == $past(sfr_wdata[1:0], 2);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power mismatch");
	property p_rdbk;
		sfr_wr && sfr_hit ##1 $stable(sfr_addr) |-> sfr_rdata == $past(sfr_wdata);
	endproperty
	a_rdbk: assert property (p_rdbk) else $error("readback mismatch");
	// a stable sync setting must freeze both codes
	property p_hold;
		!ctl_q[2] && $stable(ctl_q) && !cw |=> $stable({ch1_code, ch0_code});
	endproperty
	a_hold: assert property (p_hold) else $error("code moved in sync mode");
	property p_ch0_force_zero_n;
		!ctl_q[3] && !$past(ctl_q[3]) |-> ch0_code == 12'h000;
	endproperty
	a_ch0_force_zero_n: assert property (p_ch0_force_zero_n) else $error("ch0 not cleared");
	property p_ch1_force_zero_n;
		!ctl_q[4] && !$past(ctl_q[4]) |-> ch1_code == 12'h000;
	endproperty
	a_ch1_force_zero_n: assert property (p_ch1_force_zero_n) else $error("ch1 not cleared");
	property p_ld8;
		sfr_wr && sfr_addr == 8'hf9 && ctl_q[7] && ctl_q[3] && ctl_q[2]
		##1 !(sfr_wr && sfr_addr inside {8'hf9, 8'hfd})
		|=> ch0_code == {$past(sfr_wdata, 2), 4'h0};
	endproperty
	a_ld8: assert property (p_ld8) else $error("8-bit load wrong");
	property p_avail;
		analog_input_4_avail == !ch0_drive_en && analog_input_5_avail == !ch1_drive_en;
	endproperty
	a_avail: assert property (p_avail) else $error("pin sharing wrong");
	// main scenarios
	c_sync: cover property (!ctl_q[2] && cw && sfr_wdata[2]);
	c_pwr: cover property (ch0_drive_en && ch1_drive_en);
	c_clr: cover property (ctl_q[3] && ch0_code != 12'h000);
endmodule : analog_out_chk
bind analog_out_ctrl analog_out_chk chk (.clk_sys, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata,
	.sfr_rdata, .sfr_hit, .ch0_code, .ch1_code, .ch0_span_supply, .ch1_span_supply,
	.ch0_drive_en, .ch1_drive_en, .analog_input_4_avail, .analog_input_5_avail);
`default_nettype wire

/* test/analog_out_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module analog_out_ctrl_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	wire logic [7:0] sfr_rdata;
	wire logic sfr_hit, ch0_span_supply, ch1_span_supply, ch0_drive_en, ch1_drive_en;
	wire logic [11:0] ch0_code, ch1_code;
	wire logic analog_input_4_avail, analog_input_5_avail;
	int miscompares = 0;
	int n_compared = 0;
	always #50 clk_sys = ~clk_sys;
	analog_out_ctrl dut (.clk_sys, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
		.sfr_hit, .ch0_code, .ch0_span_supply, .ch0_drive_en, .ch1_code, .ch1_span_supply,
		.ch1_drive_en, .analog_input_4_avail, .analog_input_5_avail);
	// =====
	// bus tasks; writes stay up so they can run back to back
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
	endtask : wr
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk_sys);
			sfr_wr = 1'b0;
		end
	endtask : idle
	task automatic cmp(input string n, input logic [11:0] s, input logic [11:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		sfr_wr = 1'b0;
		sfr_addr = a;
		#1 cmp("sfr_rdata", {4'h0, sfr_rdata}, {4'h0, e});
		// hit must drop for unmapped addresses so other blocks can answer
		cmp("sfr_hit", {11'h000, sfr_hit}, {11'h000, ((a >= analog_out_pkg::OUT0_DATA_LOW_ADDR)
			&& (a <= analog_out_pkg::ANALOG_OUT_CONTROL_ADDR))});
	endtask : rd
	// f packs span1, span0, drive1, drive0
	task automatic outs(input logic [11:0] c0, input logic [11:0] c1, input logic [3:0] f);
		cmp("ch0_code", ch0_code, c0);
		cmp("ch1_code", ch1_code, c1);
		cmp("flags", {8'h00, ch1_span_supply, ch0_span_supply, ch1_drive_en, ch0_drive_en},
			{8'h00, f});
		cmp("avail", {10'h000, analog_input_5_avail, analog_input_4_avail}, {10'h000, ~f[1:0]});
	endtask : outs
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// =====
	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys) rst_n = 1'b1;
		for (int i = 0; i < 6; i++) rd(8'hf9 + 8'(i), (i == 4) ? 8'h04 : 8'h00);
		outs(12'h000, 12'h000, 4'h0);
		// input converter power sits outside this block; taken as on for reference span
		wr(8'hfd, 8'h1f);
		wr(8'hfa, 8'hf5);
		wr(8'hf9, 8'hbc);
		idle(2);
		outs(12'h5bc, 12'h000, 4'h3);
		wr(8'hfc, 8'h07);
		idle(2);
		outs(12'h5bc, 12'h000, 4'h3);
		wr(8'hfb, 8'h21);
		wr(8'hfd, 8'h17);
		idle(2);
		outs(12'h000, 12'h721, 4'h3);
		wr(8'hfd, 8'h0f);
		idle(2);
		outs(12'h5bc, 12'h000, 4'h3);
		// sync mode holds both, then loads both at once
		wr(8'hfd, 8'h1b);
		wr(8'hfa, 8'h01);
		wr(8'hf9, 8'h23);
		wr(8'hfc, 8'h04);
		wr(8'hfb, 8'h56);
		idle(2);
		outs(12'h5bc, 12'h721, 4'h3);
		wr(8'hfd, 8'h1f);
		idle(2);
		outs(12'h123, 12'h456, 4'h3);
		rd(8'hfa, 8'h01);
		wr(8'hfd, 8'h5d);
		idle(2);
		outs(12'h123, 12'h456, 4'h9);
		wr(8'hfd, 8'h3e);
		idle(2);
		outs(12'h123, 12'h456, 4'h6);
		wr(8'hfd, 8'h9f);
		wr(8'hf9, 8'h3c);
		idle(2);
		cmp("ch0_code", ch0_code, 12'h3c0);
		rd(8'hfd, 8'h9f);
		report_and_stop();
	end
	// watchdog, far beyond the expected run
	initial begin
		#50000;
		miscompares++;
		report_and_stop();
	end
endmodule : analog_out_ctrl_tb
`default_nettype wire
